/* rtl/pse_pkg.sv */
// Constants shared by the port supervisor, its flash-code sequencer and its dimming generator
package pse_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CNT_W = 28;

  localparam int unsigned UV_QUAL_US = 2500;
  localparam int unsigned UV_QUAL_CYC = UV_QUAL_US * CLK_PER_US;
  localparam int unsigned DISC_TIMEOUT_US = 300_000;
  localparam int unsigned DISC_TIMEOUT_CYC = DISC_TIMEOUT_US * CLK_PER_US;
  localparam int unsigned FAULT_TIME_US = 60_000;
  localparam int unsigned FAULT_TIME_CYC = FAULT_TIME_US * CLK_PER_US;
  localparam int unsigned FAULT_DECAY_CYC = 16;

  localparam int unsigned PWM_FREQ_HZ = 25_000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int unsigned PWM_DUTY_DIV = 16;

  localparam int unsigned FLASH_ON_US = 250_000;
  localparam int unsigned FLASH_ON_CYC = FLASH_ON_US * CLK_PER_US;
  localparam int unsigned FLASH_OFF_US = 250_000;
  localparam int unsigned FLASH_OFF_CYC = FLASH_OFF_US * CLK_PER_US;
  localparam int unsigned FLASH_PAUSE_US = 1_000_000;
  localparam int unsigned FLASH_PAUSE_CYC = FLASH_PAUSE_US * CLK_PER_US;
  localparam logic [2:0] OC_FLASHES = 3'h2;
  localparam logic [2:0] SIG_FLASHES = 3'h5;

  localparam logic [6:0] TRI_STEP_CYC = 7'h40;
  localparam logic [7:0] TRI_MAX = 8'hFF;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_ENABLE = 8'h0C;
  localparam logic [7:0] REG_INT_CLEAR = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  localparam int unsigned EV_OC = 0;
  localparam int unsigned EV_DISC = 1;
  localparam int unsigned EV_OV = 2;
  localparam int unsigned EV_THERM = 3;
  localparam int unsigned EV_SIG = 4;
  localparam int unsigned EV_W = 5;

  localparam int unsigned PIN_UV_OK = 0;
  localparam int unsigned PIN_OV = 1;
  localparam int unsigned PIN_MODE = 2;
  localparam int unsigned PIN_DC_LOW = 3;
  localparam int unsigned PIN_AC_LOW = 4;
  localparam int unsigned PIN_HOT = 5;
  localparam int unsigned PIN_COOL = 6;
  localparam int unsigned PIN_DIM = 7;
  localparam int unsigned PIN_OC = 8;
  localparam int unsigned PIN_REQ = 9;
  localparam int unsigned PIN_SIG = 10;
  localparam int unsigned PIN_W = 11;
endpackage

/* rtl/dimming_pwm.sv */
// Free-running pulse generator used to dim the status LED
module dimming_pwm #(
  parameter int unsigned PERIOD_CYC = pse_pkg::PWM_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic pwm_on
);
  typedef struct packed {
    logic [15:0] cnt;
  } pwm_state_t;

  pwm_state_t q_r;
  pwm_state_t q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (q_r.cnt >= 16'(PERIOD_CYC - 1))
      q_nxt.cnt = 16'h0000;
    else
      q_nxt.cnt = q_r.cnt + 16'h0001;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  // One sixteenth of the period high
  assign pwm_on = (q_r.cnt < 16'(PERIOD_CYC / pse_pkg::PWM_DUTY_DIV));
endmodule // dimming_pwm

/* rtl/flash_code_gen.sv */
// Sequencer that blinks a repeating series of LED flashes followed by a pause
module flash_code_gen #(
  parameter int unsigned ON_CYC = pse_pkg::FLASH_ON_CYC,
  parameter int unsigned OFF_CYC = pse_pkg::FLASH_OFF_CYC,
  parameter int unsigned PAUSE_CYC = pse_pkg::FLASH_PAUSE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [2:0] flash_count,
  output logic flash_on
);
  typedef enum logic [1:0] {PH_ON, PH_OFF, PH_PAUSE} phase_t;
  typedef struct packed {
    phase_t ph;
    logic [pse_pkg::CNT_W-1:0] cnt;
    logic [2:0] done;
  } flash_state_t;

  flash_state_t q_r;
  flash_state_t q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.cnt = q_r.cnt + 1'b1;
    case (q_r.ph)
      PH_ON:
      begin
        if (q_r.cnt >= pse_pkg::CNT_W'(ON_CYC - 1))
        begin
          q_nxt.ph = PH_OFF;
          q_nxt.cnt = '0;
          q_nxt.done = q_r.done + 3'h1;
        end
      end
      PH_OFF:
      begin
        if (q_r.cnt >= pse_pkg::CNT_W'(OFF_CYC - 1))
        begin
          q_nxt.cnt = '0;
          if (q_r.done >= flash_count)
          begin
            q_nxt.ph = PH_PAUSE;
            q_nxt.done = 3'h0;
          end
          else
            q_nxt.ph = PH_ON;
        end
      end
      PH_PAUSE:
      begin
        if (q_r.cnt >= pse_pkg::CNT_W'(PAUSE_CYC - 1))
        begin
          q_nxt.ph = PH_ON;
          q_nxt.cnt = '0;
        end
      end
      default:
      begin
        q_nxt.ph = PH_ON;
        q_nxt.cnt = '0;
      end
    endcase
    // Restart from the first flash so a new code always opens cleanly
    if (!enable)
    begin
      q_nxt.ph = PH_ON;
      q_nxt.cnt = '0;
      q_nxt.done = 3'h0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign flash_on = enable && (q_r.ph == PH_ON);
endmodule // flash_code_gen

/* rtl/pse_port_supervisor_led.sv */
// Port supervisor: lockouts, disconnect monitoring, fault timer, thermal handling, LED and registers
module pse_port_supervisor_led #(
  parameter int unsigned UV_QUAL_CYC_P = pse_pkg::UV_QUAL_CYC,
  parameter int unsigned DISC_CYC_P = pse_pkg::DISC_TIMEOUT_CYC,
  parameter int unsigned FAULT_CYC_P = pse_pkg::FAULT_TIME_CYC,
  parameter int unsigned PWM_PERIOD_P = pse_pkg::PWM_PERIOD_CYC,
  parameter int unsigned FLASH_ON_P = pse_pkg::FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF_P = pse_pkg::FLASH_OFF_CYC,
  parameter int unsigned FLASH_PAUSE_P = pse_pkg::FLASH_PAUSE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic supply_undervoltage_lockout,
  input wire logic supply_overvoltage_detect,
  input wire logic disconnect_mode_pin,
  input wire logic dc_disconnect_threshold,
  input wire logic ac_disconnect_threshold,
  input wire logic die_hot,
  input wire logic die_cool,
  input wire logic led_dimming_enable,
  input wire logic overcurrent_detect,
  input wire logic power_request,
  input wire logic signature_fault,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic port_power,
  output logic logic_in_reset,
  output logic led_sink_oe,
  output logic [7:0] probe_pin
);
  typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_POWERED, ST_OC_OFF} port_state_t;
  typedef struct packed {
    logic [pse_pkg::PIN_W-1:0] sync1;
    logic [pse_pkg::PIN_W-1:0] sync2;
    port_state_t st;
    logic ac_mode;
    logic therm_fault;
    logic oc_fault;
    logic sig_fault;
    logic [pse_pkg::CNT_W-1:0] uv_cnt;
    logic [pse_pkg::CNT_W-1:0] disc_cnt;
    logic [pse_pkg::CNT_W-1:0] fault_cnt;
    logic [4:0] decay_cnt;
    logic [7:0] tri_code;
    logic tri_down;
    logic [6:0] tri_div;
    logic [31:0] ctrl;
    logic [pse_pkg::EV_W-1:0] int_status;
    logic [pse_pkg::EV_W-1:0] int_enable;
    logic [31:0] rdata;
    logic irq;
    logic port_power;
    logic in_reset;
    logic led_sink;
    logic [7:0] probe;
  } sup_state_t;

  sup_state_t q_r;
  sup_state_t q_nxt;
  logic pwm_on;
  logic oc_flash;
  logic sig_flash;

  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] offs);
    reg_hit = strobe && (addr == offs);
  endfunction

  function automatic logic [6:0] tri_step_m1();
    tri_step_m1 = pse_pkg::TRI_STEP_CYC - 7'h01;
  endfunction

  dimming_pwm #(
    .PERIOD_CYC(PWM_PERIOD_P)
  ) u_pwm (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pwm_on(pwm_on)
  );

  flash_code_gen #(
    .ON_CYC(FLASH_ON_P),
    .OFF_CYC(FLASH_OFF_P),
    .PAUSE_CYC(FLASH_PAUSE_P)
  ) u_oc_flash (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(q_r.oc_fault),
    .flash_count(pse_pkg::OC_FLASHES),
    .flash_on(oc_flash)
  );

  flash_code_gen #(
    .ON_CYC(FLASH_ON_P),
    .OFF_CYC(FLASH_OFF_P),
    .PAUSE_CYC(FLASH_PAUSE_P)
  ) u_sig_flash (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(q_r.sig_fault),
    .flash_count(pse_pkg::SIG_FLASHES),
    .flash_on(sig_flash)
  );

  always_comb
  begin
    logic [pse_pkg::PIN_W-1:0] s;
    logic [pse_pkg::EV_W-1:0] ev;
    logic [pse_pkg::EV_W-1:0] clr;
    logic disc_low;
    logic decay_tick;
    logic led_on;
    s = q_r.sync2;
    ev = '0;
    clr = '0;
    disc_low = 1'b0;
    decay_tick = 1'b0;
    led_on = 1'b0;
    q_nxt = q_r;
    q_nxt.sync1 = {signature_fault, power_request, overcurrent_detect, led_dimming_enable, die_cool, die_hot,
                   ac_disconnect_threshold, dc_disconnect_threshold, disconnect_mode_pin,
                   supply_overvoltage_detect, supply_undervoltage_lockout};
    q_nxt.sync2 = q_r.sync1;

    if (q_r.uv_cnt < pse_pkg::CNT_W'(UV_QUAL_CYC_P))
      q_nxt.uv_cnt = q_r.uv_cnt + 1'b1;

    // Slow decay lets repeated short overloads still build up to a fault
    if (q_r.decay_cnt >= 5'(pse_pkg::FAULT_DECAY_CYC - 1))
    begin
      q_nxt.decay_cnt = 5'h00;
      decay_tick = 1'b1;
    end
    else
      q_nxt.decay_cnt = q_r.decay_cnt + 5'h01;

    case (q_r.st)
      ST_RESET:
      begin
        q_nxt.port_power = 1'b0;
        q_nxt.oc_fault = 1'b0;
        q_nxt.sig_fault = 1'b0;
        q_nxt.fault_cnt = '0;
        if (q_r.uv_cnt >= pse_pkg::CNT_W'(UV_QUAL_CYC_P) && !q_r.therm_fault)
        begin
          q_nxt.st = ST_IDLE;
          q_nxt.ac_mode = s[pse_pkg::PIN_MODE];
        end
      end
      ST_IDLE:
      begin
        if (s[pse_pkg::PIN_SIG])
        begin
          q_nxt.sig_fault = 1'b1;
          q_nxt.oc_fault = 1'b0;
          ev[pse_pkg::EV_SIG] = 1'b1;
        end
        else if (s[pse_pkg::PIN_REQ] && q_r.ctrl[0] && !s[pse_pkg::PIN_OV])
        begin
          q_nxt.st = ST_POWERED;
          q_nxt.port_power = 1'b1;
          q_nxt.disc_cnt = '0;
          q_nxt.fault_cnt = '0;
          q_nxt.oc_fault = 1'b0;
          q_nxt.sig_fault = 1'b0;
        end
      end
      ST_POWERED:
      begin
        if (s[pse_pkg::PIN_OC])
          q_nxt.fault_cnt = q_r.fault_cnt + 1'b1;
        else if (decay_tick && q_r.fault_cnt != '0)
          q_nxt.fault_cnt = q_r.fault_cnt - 1'b1;
        disc_low = q_r.ac_mode ? s[pse_pkg::PIN_AC_LOW] : s[pse_pkg::PIN_DC_LOW];
        q_nxt.disc_cnt = disc_low ? q_r.disc_cnt + 1'b1 : '0;
        if (q_r.fault_cnt >= pse_pkg::CNT_W'(FAULT_CYC_P))
        begin
          q_nxt.st = ST_OC_OFF;
          q_nxt.port_power = 1'b0;
          q_nxt.oc_fault = 1'b1;
          q_nxt.fault_cnt = q_r.fault_cnt;
          ev[pse_pkg::EV_OC] = 1'b1;
        end
        else if (q_r.disc_cnt >= pse_pkg::CNT_W'(DISC_CYC_P))
        begin
          q_nxt.st = ST_IDLE;
          q_nxt.port_power = 1'b0;
          ev[pse_pkg::EV_DISC] = 1'b1;
        end
        else if (!q_r.ctrl[0])
        begin
          q_nxt.st = ST_IDLE;
          q_nxt.port_power = 1'b0;
        end
      end
      ST_OC_OFF:
      begin
        q_nxt.port_power = 1'b0;
        if (q_r.fault_cnt == '0)
          q_nxt.st = ST_IDLE;
        else if (decay_tick)
          q_nxt.fault_cnt = q_r.fault_cnt - 1'b1;
      end
      default:
        q_nxt.st = ST_RESET;
    endcase

    if (s[pse_pkg::PIN_OV])
    begin
      q_nxt.port_power = 1'b0;
      if (q_r.st == ST_POWERED)
        q_nxt.st = ST_IDLE;
      if (q_r.port_power)
        ev[pse_pkg::EV_OV] = 1'b1;
    end

    if (s[pse_pkg::PIN_HOT] && !q_r.therm_fault)
    begin
      q_nxt.therm_fault = 1'b1;
      ev[pse_pkg::EV_THERM] = 1'b1;
    end
    else if (q_r.therm_fault && s[pse_pkg::PIN_COOL] && !s[pse_pkg::PIN_HOT])
      q_nxt.therm_fault = 1'b0;

    // Thermal fault and lockout both force reset; requalification follows their release
    if (q_nxt.therm_fault || !s[pse_pkg::PIN_UV_OK])
    begin
      q_nxt.st = ST_RESET;
      q_nxt.port_power = 1'b0;
      q_nxt.uv_cnt = '0;
    end
    q_nxt.in_reset = (q_nxt.st == ST_RESET);

    if (q_r.ac_mode && q_r.st != ST_RESET)
    begin
      if (q_r.tri_div >= tri_step_m1())
      begin
        q_nxt.tri_div = 7'h00;
        if (q_r.tri_down)
        begin
          q_nxt.tri_code = q_r.tri_code - 8'h01;
          q_nxt.tri_down = (q_r.tri_code != 8'h01);
        end
        else
        begin
          q_nxt.tri_code = q_r.tri_code + 8'h01;
          q_nxt.tri_down = (q_r.tri_code == pse_pkg::TRI_MAX - 8'h01);
        end
      end
      else
        q_nxt.tri_div = q_r.tri_div + 7'h01;
      q_nxt.probe = q_r.tri_code;
    end
    else
    begin
      q_nxt.tri_div = 7'h00;
      q_nxt.tri_code = 8'h00;
      q_nxt.tri_down = 1'b0;
      q_nxt.probe = 8'h00;
    end

    if (q_r.oc_fault)
      led_on = oc_flash;
    else if (q_r.sig_fault)
      led_on = sig_flash;
    else
      led_on = (q_r.st == ST_POWERED) && q_r.port_power;
    q_nxt.led_sink = led_on && (!s[pse_pkg::PIN_DIM] || pwm_on);

    if (reg_hit(reg_wr, reg_addr, pse_pkg::REG_CTRL))
      q_nxt.ctrl = {31'h0000_0000, reg_wdata[0]};
    if (reg_hit(reg_wr, reg_addr, pse_pkg::REG_INT_ENABLE))
      q_nxt.int_enable = reg_wdata[pse_pkg::EV_W-1:0];
    if (reg_hit(reg_wr, reg_addr, pse_pkg::REG_INT_CLEAR))
      clr = reg_wdata[pse_pkg::EV_W-1:0];
    // A new event outranks a clear in the same cycle
    q_nxt.int_status = (q_r.int_status & ~clr) | ev;
    q_nxt.irq = |(q_nxt.int_status & q_nxt.int_enable);

    q_nxt.rdata = 32'h0000_0000;
    if (reg_hit(reg_rd, reg_addr, pse_pkg::REG_CTRL))
      q_nxt.rdata = q_r.ctrl;
    if (reg_hit(reg_rd, reg_addr, pse_pkg::REG_STATUS))
      q_nxt.rdata = {24'h00_0000, q_r.in_reset, q_r.ac_mode, q_r.therm_fault, q_r.oc_fault,
                     q_r.sig_fault, q_r.port_power, q_r.st};
    if (reg_hit(reg_rd, reg_addr, pse_pkg::REG_INT_STATUS))
      q_nxt.rdata = {27'h000_0000, q_r.int_status};
    if (reg_hit(reg_rd, reg_addr, pse_pkg::REG_INT_ENABLE))
      q_nxt.rdata = {27'h000_0000, q_r.int_enable};
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q_r <= '0;
      q_r.st <= ST_RESET;
      q_r.in_reset <= 1'b1;
      q_r.ctrl <= pse_pkg::CTRL_RST;
    end
    else
      q_r <= q_nxt;
  end

  assign reg_rdata = q_r.rdata;
  assign irq = q_r.irq;
  assign port_power = q_r.port_power;
  assign logic_in_reset = q_r.in_reset;
  assign led_sink_oe = q_r.led_sink;
  assign probe_pin = q_r.probe;
endmodule // pse_port_supervisor_led

/* verification/pse_checker.sv */
// Port-level assertion checker for the port supervisor
module pse_checker #(
  parameter int unsigned FAULT_P = 40,
  parameter int unsigned DISC_P = 30
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic supply_undervoltage_lockout,
  input wire logic supply_overvoltage_detect,
  input wire logic dc_disconnect_threshold,
  input wire logic ac_disconnect_threshold,
  input wire logic die_hot,
  input wire logic led_dimming_enable,
  input wire logic overcurrent_detect,
  input wire logic port_power,
  input wire logic logic_in_reset,
  input wire logic led_sink_oe,
  input wire logic [7:0] probe_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] oc_cnt_r;
  logic [31:0] low_cnt_r;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Margins of five or six cycles cover input synchronisers and registered outputs
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oc_cnt_r <= 32'h0;
      low_cnt_r <= 32'h0;
    end
    else
    begin
      oc_cnt_r <= (port_power && overcurrent_detect) ? oc_cnt_r + 32'h1 : 32'h0;
      low_cnt_r <= (port_power && dc_disconnect_threshold && ac_disconnect_threshold) ? low_cnt_r + 32'h1 : 32'h0;
    end
  end
  a_ov_port_off: assert property (supply_overvoltage_detect [*5] |-> !port_power)
    else $error("port powered during overvoltage");
  a_uv_holds_reset: assert property (!supply_undervoltage_lockout [*5] |-> logic_in_reset)
    else $error("logic left reset without good supply");
  a_reset_unpowered: assert property (logic_in_reset [*2] |-> !port_power)
    else $error("port powered while in reset");
  a_probe_quiet: assert property (logic_in_reset [*2] |-> probe_pin == 8'h00)
    else $error("probe driven while in reset");
  a_hot_shutdown: assert property (die_hot [*5] |-> logic_in_reset && !port_power)
    else $error("no shutdown on hot die");
  a_dim_duty: assert property ((led_dimming_enable && port_power) [*6] ##0 led_sink_oe [*2] |=> !led_sink_oe)
    else $error("dimmed led pulse too long");
  a_led_steady: assert property ((!led_dimming_enable && port_power) [*5] |-> led_sink_oe)
    else $error("led dark while powered undimmed");
  a_fault_limit: assert property (oc_cnt_r >= FAULT_P + 6 |-> !port_power)
    else $error("overcurrent outlasted fault timer");
  a_disc_limit: assert property (low_cnt_r >= DISC_P + 6 |-> !port_power)
    else $error("port kept on after load removal");
endmodule // pse_checker

bind pse_port_supervisor_led pse_checker #(.FAULT_P(FAULT_CYC_P), .DISC_P(DISC_CYC_P)) chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .supply_undervoltage_lockout(supply_undervoltage_lockout),
  .supply_overvoltage_detect(supply_overvoltage_detect),
  .dc_disconnect_threshold(dc_disconnect_threshold),
  .ac_disconnect_threshold(ac_disconnect_threshold),
  .die_hot(die_hot),
  .led_dimming_enable(led_dimming_enable),
  .overcurrent_detect(overcurrent_detect),
  .port_power(port_power),
  .logic_in_reset(logic_in_reset),
  .led_sink_oe(led_sink_oe),
  .probe_pin(probe_pin)
);

/* verification/pd_model.sv */
// Behavioural powered device on the far side of the port
module pd_model #(
  parameter int LAG = 2
) (
  input wire logic core_clk,
  input wire logic present,
  input wire logic overload,
  input wire logic sig_bad,
  output logic power_request,
  output logic signature_fault,
  output logic dc_low,
  output logic ac_low,
  output logic oc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pipe_r = 8'h00;
  // Detection and classification take time after plug-in
  always @(posedge core_clk)
    pipe_r <= {pipe_r[6:0], present && !sig_bad};
  assign power_request = pipe_r[LAG];
  assign signature_fault = sig_bad;
  // A removed device draws nothing, so both sense paths read low
  assign dc_low = !present;
  assign ac_low = !present;
  assign oc = present && overload;
endmodule // pd_model

/* verification/tb.sv */
// Self-checking bench for the port supervisor
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UVQ = 20;
  localparam int DSC = 30;
  localparam int FLT = 40;
  localparam int PWM = 32;
  localparam int FOFF = 5;
  localparam int FPAU = 20;
  logic core_clk, sys_rst, uv, ov, mode, hot, cool, dim, reg_wr, reg_rd, irq, port_power, logic_in_reset;
  logic led_sink_oe, present, overload, sig_bad, req, sigf, dcl, acl, oc;
  logic [7:0] reg_addr, probe_pin, pmin, pmax;
  logic [31:0] reg_wdata, reg_rdata;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int last, hi, mo;
  pd_model pd (.core_clk(core_clk), .present(present), .overload(overload), .sig_bad(sig_bad),
    .power_request(req), .signature_fault(sigf), .dc_low(dcl), .ac_low(acl), .oc(oc));
  pse_port_supervisor_led #(.UV_QUAL_CYC_P(UVQ), .DISC_CYC_P(DSC), .FAULT_CYC_P(FLT), .PWM_PERIOD_P(PWM),
    .FLASH_ON_P(5), .FLASH_OFF_P(FOFF), .FLASH_PAUSE_P(FPAU)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .supply_undervoltage_lockout(uv), .supply_overvoltage_detect(ov), .disconnect_mode_pin(mode),
    .dc_disconnect_threshold(dcl), .ac_disconnect_threshold(acl), .die_hot(hot), .die_cool(cool),
    .led_dimming_enable(dim), .overcurrent_detect(oc), .power_request(req), .signature_fault(sigf),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .port_power(port_power), .logic_in_reset(logic_in_reset), .led_sink_oe(led_sink_oe),
    .probe_pin(probe_pin));
  always #4 core_clk = ~core_clk;
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Bounded wait on port power (which=0) or the reset flag (which=1)
  task automatic wt(input bit which, input logic v, input int lim);
    int i;
    i = 0;
    // Never look at an output in the time step of the edge that launches it
    #1;
    while ((which ? logic_in_reset : port_power) !== v && i < lim)
    begin
      step(1);
      i++;
    end
    `CHK(which ? logic_in_reset : port_power, v)
  endtask
  // Flashes in the last whole series, lit cycles, longest dark run
  task automatic watch(input int n);
    int off, grp;
    off = 0;
    grp = 0;
    last = 0;
    hi = 0;
    mo = 0;
    repeat (n)
    begin
      step(1);
      if (led_sink_oe === 1'b1)
      begin
        if (off > FOFF)
          last = grp;
        grp = (off > FOFF) ? 1 : (off > 0 ? grp + 1 : grp);
        hi++;
        off = 0;
      end
      else
        off++;
      mo = (off > mo) ? off : mo;
    end
  endtask
  initial
  begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {uv, ov, mode, hot, dim, reg_wr, reg_rd, present, overload, sig_bad} = 10'h000;
    cool = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    step(20);
    @(posedge core_clk) sys_rst <= 1'b0;
    rchk(pse_pkg::REG_CTRL, pse_pkg::CTRL_RST);
    rchk(8'h20, 32'h0);
    @(posedge core_clk) uv <= 1'b1;
    step(UVQ);
    `CHK(logic_in_reset, 1'b1)
    wt(1, 1'b0, 12);
    $display("lockout test done");
    wr(pse_pkg::REG_INT_ENABLE, 32'h0);
    @(posedge core_clk) sig_bad <= 1'b1;
    watch(200);
    `CHK(last, int'(pse_pkg::SIG_FLASHES))
    `CHK(mo >= FPAU, 1'b1)
    rchk(pse_pkg::REG_INT_STATUS, 32'h1 << pse_pkg::EV_SIG);
    `CHK(irq, 1'b0)
    wr(pse_pkg::REG_INT_ENABLE, 32'h1F);
    step(2);
    `CHK(irq, 1'b1)
    @(posedge core_clk) sig_bad <= 1'b0;
    step(3);
    wr(pse_pkg::REG_INT_CLEAR, 32'h1F);
    step(2);
    `CHK(irq, 1'b0)
    $display("signature test done");
    @(posedge core_clk) present <= 1'b1;
    wt(0, 1'b1, 12);
    step(3);
    `CHK(led_sink_oe, 1'b1)
    rchk(pse_pkg::REG_STATUS, 32'h06);
    @(posedge core_clk) dim <= 1'b1;
    step(6);
    watch(64);
    `CHK(hi, 2 * PWM / pse_pkg::PWM_DUTY_DIV)
    @(posedge core_clk) overload <= 1'b1;
    step(FLT - 15);
    @(posedge core_clk) overload <= 1'b0;
    present <= 1'b0;
    step(DSC - 5);
    `CHK(port_power, 1'b1)
    wt(0, 1'b0, 15);
    rchk(pse_pkg::REG_INT_STATUS, 32'h1 << pse_pkg::EV_DISC);
    watch(40);
    `CHK(hi, 0)
    wr(pse_pkg::REG_INT_CLEAR, 32'h1F);
    $display("dc disconnect test done");
    @(posedge core_clk) present <= 1'b1;
    wt(0, 1'b1, 12);
    @(posedge core_clk) ov <= 1'b1;
    wt(0, 1'b0, 6);
    step(10);
    `CHK(port_power, 1'b0)
    @(posedge core_clk) ov <= 1'b0;
    wt(0, 1'b1, 12);
    rchk(pse_pkg::REG_INT_STATUS, 32'h1 << pse_pkg::EV_OV);
    wr(pse_pkg::REG_INT_CLEAR, 32'h1F);
    $display("overvoltage test done");
    wr(pse_pkg::REG_CTRL, 32'h0);
    wt(0, 1'b0, 6);
    rchk(pse_pkg::REG_CTRL, 32'h0);
    step(10);
    `CHK(port_power, 1'b0)
    wr(pse_pkg::REG_CTRL, pse_pkg::CTRL_RST);
    wt(0, 1'b1, 12);
    $display("port enable test done");
    // Flash counting needs undimmed pulses
    @(posedge core_clk) overload <= 1'b1;
    dim <= 1'b0;
    step(FLT - 5);
    `CHK(port_power, 1'b1)
    wt(0, 1'b0, 15);
    @(posedge core_clk) overload <= 1'b0;
    watch(100);
    `CHK(last, int'(pse_pkg::OC_FLASHES))
    `CHK(port_power, 1'b0)
    rchk(pse_pkg::REG_INT_STATUS, 32'h1 << pse_pkg::EV_OC);
    wt(0, 1'b1, 800);
    $display("overcurrent test done");
    @(posedge core_clk) hot <= 1'b1;
    cool <= 1'b0;
    wt(1, 1'b1, 6);
    `CHK(port_power, 1'b0)
    @(posedge core_clk) hot <= 1'b0;
    step(40);
    `CHK(logic_in_reset, 1'b1)
    @(posedge core_clk) cool <= 1'b1;
    wt(1, 1'b0, UVQ + 10);
    $display("thermal test done");
    @(posedge core_clk) mode <= 1'b1;
    sys_rst <= 1'b1;
    step(3);
    @(posedge core_clk) sys_rst <= 1'b0;
    wt(1, 1'b0, UVQ + 10);
    wt(0, 1'b1, 12);
    rchk(pse_pkg::REG_STATUS, 32'h46);
    pmin = 8'hFF;
    pmax = 8'h00;
    repeat (300)
    begin
      step(1);
      pmin = (probe_pin < pmin) ? probe_pin : pmin;
      pmax = (probe_pin > pmax) ? probe_pin : pmax;
    end
    `CHK(pmax > pmin, 1'b1)
    @(posedge core_clk) present <= 1'b0;
    wt(0, 1'b0, DSC + 15);
    $display("ac disconnect test done");
    print_verdict;
  end
endmodule // tb
